// ### hw/fault_sync.sv
// Two-stage synchroniser for the back-end fault input
`default_nettype none
module fault_sync (
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Level in and out
	input  wire logic din,
	output logic      dout
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	// Resets to the idle (high) level so reset is not seen as a fault
	always_ff @(posedge clock) begin
		if (srst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : fault_sync
`default_nettype wire

// ### hw/interval_timer.sv
// Interval timer counting 0.1 ms ticks of the system clock
`include "pwm_ctrl_params.svh"
`default_nettype none
module interval_timer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic srst,
	// Control
	interval_if.timer t
);
	localparam int PW = $clog2(TICK_CYCLES + 1);
	logic [PW-1:0]        pre_q;
	logic [PW-1:0]        pre_d;
	pwm_ctrl_pkg::ticks_t cnt_q;
	pwm_ctrl_pkg::ticks_t cnt_d;
	logic                 busy_q;
	logic                 busy_d;
	logic                 done_q;
	logic                 done_d;

	always_comb begin
		pre_d  = pre_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (t.abort) begin
			busy_d = 1'b0;
		end else if (t.load) begin
			pre_d  = '0;
			cnt_d  = t.ticks;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (pre_q == PW'(TICK_CYCLES - 1)) begin  // [R16]
				pre_d = '0;
				if (cnt_q <= 18'h0_0001) begin
					cnt_d  = '0;
					busy_d = 1'b0;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 18'h0_0001;
				end
			end else begin
				pre_d = pre_q + PW'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pre_q  <= '0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			pre_q  <= pre_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign t.busy = busy_q;
	assign t.done = done_q;
endmodule : interval_timer
`default_nettype wire

// ### hw/pwm_softstart_ctrl.sv
// Soft start/stop, oscillator trim and back-end fault control with APB
//
// The APB slave port was left to the implementer.
`include "pwm_ctrl_params.svh"
`default_nettype none
module pwm_softstart_ctrl #(
	parameter int CHANNELS    = 6,
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int HALF_PWM    = `HALF_PWM_CYCLES
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                srst,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [9:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Channel control and modulator data
	input  wire logic                channels_on,
	input  wire logic [CHANNELS-1:0] pwm_in,
	// Power stage
	input  wire logic                backend_fault_n,
	output logic [CHANNELS-1:0]      pwm_out,
	output logic                     output_valid_a,
	output logic                     output_valid_b,
	output logic                     bridge_tied_load,
	output logic                     single_ended_load,
	// Modulator reset and oscillator
	output logic                     modulator_reset,
	output logic                     factory_trim_select,
	// Interrupt
	output logic                     irq
);
	// ----------------------------------------------------------------
	// Lookup tables, in 0.1 ms ticks
	// ----------------------------------------------------------------
	function automatic pwm_ctrl_pkg::ticks_t soft_ticks(
		input logic [4:0] code
	);
		unique case (code)
			5'h08: soft_ticks = 18'd165;     // [R4]
			5'h09: soft_ticks = 18'd239;
			5'h0A: soft_ticks = 18'd314;
			5'h0B: soft_ticks = 18'd404;
			5'h0C: soft_ticks = 18'd539;
			5'h0D: soft_ticks = 18'd703;
			5'h0E: soft_ticks = 18'd942;
			5'h0F: soft_ticks = 18'd1257;
			5'h10: soft_ticks = 18'd1646;    // [R5]
			5'h11: soft_ticks = 18'd2394;
			5'h12: soft_ticks = 18'd3142;
			5'h13: soft_ticks = 18'd4039;
			5'h14: soft_ticks = 18'd5386;
			5'h15: soft_ticks = 18'd7031;
			5'h16: soft_ticks = 18'd9425;
			5'h17: soft_ticks = 18'd12566;
			5'h18: soft_ticks = 18'd17281;   // [R6]
			5'h19: soft_ticks = 18'd25136;
			5'h1A: soft_ticks = 18'd32991;
			5'h1B: soft_ticks = 18'd42417;
			5'h1C: soft_ticks = 18'd56556;
			5'h1D: soft_ticks = 18'd73837;
			5'h1E: soft_ticks = 18'd98973;
			5'h1F: soft_ticks = 18'd131964;
			default: soft_ticks = 18'd0;     // [R3]
		endcase
	endfunction : soft_ticks

	// Reserved codes 0 and 1 still give their listed times
	function automatic pwm_ctrl_pkg::ticks_t backend_ticks(
		input logic [3:0] code
	);
		unique case (code)
			4'h0: backend_ticks = 18'd0;
			4'h1: backend_ticks = 18'd1500;
			4'h2: backend_ticks = 18'd2990;    // [R13]
			4'h3: backend_ticks = 18'd4490;
			4'h4: backend_ticks = 18'd5980;
			4'h5: backend_ticks = 18'd7480;
			4'h6: backend_ticks = 18'd8980;
			4'h7: backend_ticks = 18'd10470;
			4'h8: backend_ticks = 18'd11970;
			4'h9: backend_ticks = 18'd13460;
			default: backend_ticks = 18'd14960; // [R14]
		endcase
	endfunction : backend_ticks

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int HW = $clog2(HALF_PWM + 1);

	logic [7:0]            ss_q;
	logic [7:0]            ss_d;
	logic                  trim_dis_q;
	logic                  trim_dis_d;
	logic                  trim_done_q;
	logic                  trim_done_d;
	logic [3:0]            bk_q;
	logic [3:0]            bk_d;
	logic [`IRQ_BITS-1:0]  stat_q;
	logic [`IRQ_BITS-1:0]  stat_d;
	logic [`IRQ_BITS-1:0]  mask_q;
	logic [`IRQ_BITS-1:0]  mask_d;
	logic [31:0]           rd_q;
	logic [31:0]           rd_d;
	logic [31:0]           rd_mux;

	pwm_ctrl_pkg::ch_state_t st_q;
	pwm_ctrl_pkg::ch_state_t st_d;
	logic [CHANNELS-1:0]   pwm_q;
	logic [CHANNELS-1:0]   pwm_d;
	logic                  valid_q;
	logic                  valid_d;
	logic                  mrst_q;
	logic                  mrst_d;
	logic [HW-1:0]         half_cnt_q;
	logic [HW-1:0]         half_cnt_d;
	logic                  half_q;
	logic                  half_d;

	logic                  fault_n_s;
	logic                  wr_en;
	logic                  setup;
	logic                  mapped;
	logic [7:0]            idx;
	logic [`IRQ_BITS-1:0]  ev;
	logic                  no_soft;

	interval_if soft_t ();
	interval_if bk_t ();
	interval_if trim_t ();

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	fault_sync u_sync (
		.clock (clock),
		.srst  (srst),
		.din   (backend_fault_n),
		.dout  (fault_n_s)           // [R16]
	);

	interval_timer #(.TICK_CYCLES(TICK_CYCLES)) u_soft (
		.clock (clock),
		.srst  (srst),
		.t     (soft_t.timer)
	);

	interval_timer #(.TICK_CYCLES(TICK_CYCLES)) u_bk (
		.clock (clock),
		.srst  (srst),
		.t     (bk_t.timer)
	);

	interval_timer #(.TICK_CYCLES(TICK_CYCLES)) u_trim (
		.clock (clock),
		.srst  (srst),
		.t     (trim_t.timer)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero wait states: pready is held high, read data is registered
	// in the setup cycle so it is stable through the access phase.
	assign idx    = paddr[9:2];
	assign mapped = (paddr[1:0] == 2'b00) &&
		(idx == `IDX_START_STOP || idx == `IDX_OSC_TRIM ||
		 idx == `IDX_BACKEND || idx == `IDX_IRQ_STATUS ||
		 idx == `IDX_IRQ_MASK);
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (mapped) begin
			unique case (idx)
				`IDX_START_STOP: rd_mux[7:0] = ss_q;
				`IDX_OSC_TRIM: begin
					rd_mux[7:0] = `TRIM_RSVD_ONES;
					rd_mux[`TRIM_DONE_BIT] = trim_done_q;  // [R7]
					rd_mux[`TRIM_DIS_BIT]  = trim_dis_q;
				end
				`IDX_BACKEND:    rd_mux[3:0] = bk_q;
				`IDX_IRQ_STATUS: rd_mux[`IRQ_BITS-1:0] = stat_q;
				default:         rd_mux[`IRQ_BITS-1:0] = mask_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_comb begin
		ss_d       = ss_q;
		bk_d       = bk_q;
		mask_d     = mask_q;
		trim_dis_d = trim_dis_q;
		rd_d       = setup ? rd_mux : rd_q;
		if (wr_en) begin
			unique case (idx)
				`IDX_START_STOP: ss_d = pwdata[7:0];
				`IDX_OSC_TRIM:
					trim_dis_d = pwdata[`TRIM_DIS_BIT];  // [R8]
				`IDX_BACKEND:    bk_d = pwdata[3:0];
				`IDX_IRQ_MASK:   mask_d = pwdata[`IRQ_BITS-1:0];
				default:         ;
			endcase
		end
	end

	// Trim runs each time the disable bit is written to 0; the done
	// flag drops again whenever trim is disabled.
	assign trim_t.load  = wr_en && idx == `IDX_OSC_TRIM &&
		!pwdata[`TRIM_DIS_BIT];                          // [R8]
	assign trim_t.abort = trim_dis_d;
	assign trim_t.ticks = `TRIM_TICKS;

	always_comb begin
		trim_done_d = trim_done_q;
		if (trim_t.load || trim_dis_d) begin
			trim_done_d = 1'b0;
		end else if (trim_t.done) begin
			trim_done_d = 1'b1;                              // [R7]
		end
	end

	// Status is write-one-to-clear; a new event wins over the clear
	always_comb begin
		stat_d = stat_q;
		if (wr_en && idx == `IDX_IRQ_STATUS) begin
			stat_d = stat_q & ~pwdata[`IRQ_BITS-1:0];
		end
		stat_d = stat_d | ev;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ss_q        <= `RST_START_STOP;
			trim_dis_q  <= 1'b1;                             // [R8]
			trim_done_q <= 1'b0;
			bk_q        <= 4'h2;                             // [R13]
			stat_q      <= '0;
			mask_q      <= '0;
			rd_q        <= 32'h0000_0000;
		end else begin
			ss_q        <= ss_d;
			trim_dis_q  <= trim_dis_d;
			trim_done_q <= trim_done_d;
			bk_q        <= bk_d;
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			rd_q        <= rd_d;
		end
	end

	// ----------------------------------------------------------------
	// Channel sequencer
	// ----------------------------------------------------------------
	assign no_soft = (ss_q[4:3] == 2'b00);               // [R3]
	assign soft_t.ticks = soft_ticks(ss_q[4:0]);
	assign bk_t.ticks   = backend_ticks(bk_q);

	always_comb begin
		st_d         = st_q;
		soft_t.load  = 1'b0;
		soft_t.abort = 1'b0;
		bk_t.load    = 1'b0;
		bk_t.abort   = 1'b0;
		mrst_d       = 1'b0;
		ev           = '0;
		ev[4]        = trim_t.done;
		// A fault overrides any sequence in progress
		if (!fault_n_s && st_q != pwm_ctrl_pkg::CH_FAULT_WAIT) begin
			st_d         = pwm_ctrl_pkg::CH_FAULT_WAIT;  // [R11]
			soft_t.abort = 1'b1;
			bk_t.load    = 1'b1;                         // [R12]
			ev[2]        = 1'b1;
		end else begin
			unique case (st_q)
				pwm_ctrl_pkg::CH_OFF: begin
					if (channels_on) begin
						if (no_soft) begin
							st_d = pwm_ctrl_pkg::CH_RUN;
						end else begin
							st_d = pwm_ctrl_pkg::CH_SOFT_START;
							soft_t.load = 1'b1;          // [R1]
						end
					end
				end
				pwm_ctrl_pkg::CH_SOFT_START: begin
					if (!channels_on) begin
						st_d = pwm_ctrl_pkg::CH_SOFT_STOP;
						soft_t.load = 1'b1;
					end else if (soft_t.done) begin
						st_d  = pwm_ctrl_pkg::CH_RUN;
						ev[0] = 1'b1;
					end
				end
				pwm_ctrl_pkg::CH_RUN: begin
					if (!channels_on) begin
						if (no_soft) begin
							st_d = pwm_ctrl_pkg::CH_OFF;
						end else begin
							st_d = pwm_ctrl_pkg::CH_SOFT_STOP;
							soft_t.load = 1'b1;          // [R1]
						end
					end
				end
				pwm_ctrl_pkg::CH_SOFT_STOP: begin
					if (soft_t.done) begin
						st_d  = pwm_ctrl_pkg::CH_OFF;
						ev[1] = 1'b1;
					end
				end
				pwm_ctrl_pkg::CH_FAULT_WAIT: begin
					if (bk_t.done) begin
						// A fault still present restarts the wait
						if (!fault_n_s) begin
							bk_t.load = 1'b1;
						end else begin
							st_d   = pwm_ctrl_pkg::CH_OFF;
							mrst_d = 1'b1;               // [R12]
							ev[3]  = 1'b1;
						end
					end
				end
				default: st_d = pwm_ctrl_pkg::CH_OFF;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// 50% square and output drive
	// ----------------------------------------------------------------
	always_comb begin
		half_cnt_d = half_cnt_q + HW'(1);
		half_d     = half_q;
		if (half_cnt_q == HW'(HALF_PWM - 1)) begin
			half_cnt_d = '0;
			half_d     = !half_q;                        // [R1]
		end
		pwm_d   = '0;
		valid_d = 1'b0;
		unique case (st_d)
			pwm_ctrl_pkg::CH_RUN: begin
				pwm_d   = pwm_in;
				valid_d = 1'b1;
			end
			pwm_ctrl_pkg::CH_SOFT_START,
			pwm_ctrl_pkg::CH_SOFT_STOP: begin
				pwm_d   = {CHANNELS{half_q}};            // [R1]
				valid_d = 1'b1;
			end
			default: begin
				pwm_d   = '0;                            // [R11]
				valid_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q       <= pwm_ctrl_pkg::CH_OFF;
			pwm_q      <= '0;
			valid_q    <= 1'b0;
			mrst_q     <= 1'b0;
			half_cnt_q <= '0;
			half_q     <= 1'b0;
		end else begin
			st_q       <= st_d;
			pwm_q      <= pwm_d;
			valid_q    <= valid_d;
			mrst_q     <= mrst_d;
			half_cnt_q <= half_cnt_d;
			half_q     <= half_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata              = rd_q;
	assign pwm_out             = pwm_q;
	assign output_valid_a      = valid_q;                // [R11]
	assign output_valid_b      = valid_q;
	assign bridge_tied_load    = !ss_q[`SS_LOAD_BIT];    // [R2]
	assign single_ended_load   = ss_q[`SS_LOAD_BIT];
	assign modulator_reset     = mrst_q;
	assign factory_trim_select = !trim_dis_q;
	assign irq                 = |(stat_q & mask_q);
endmodule : pwm_softstart_ctrl
`default_nettype wire

// ### inc/interval_if.sv
// Load, abort and completion signals of one interval timer
`default_nettype none
interface interval_if;
	logic                 load;
	logic                 abort;
	pwm_ctrl_pkg::ticks_t ticks;
	logic                 busy;
	logic                 done;
	modport owner (output load, output abort, output ticks,
		input busy, input done);
	modport timer (input load, input abort, input ticks,
		output busy, output done);
endinterface : interval_if
`default_nettype wire

// ### inc/pwm_ctrl_params.svh
// Offsets, reset values and timing constants of the PWM control block
// How it works
// [R1] Starting or stopping channels switches their PWM at 50% duty for the period.
// [R2] Bit 7 of the period register picks bridge-tied (0) or single-ended (1).
// [R3] Period bits 4 and 3 both zero means no 50% interval at all.
// [R4] Codes 01000 to 01111 give 16.5 up to 125.7 ms.
// [R5] Codes 10000 to 10111 give 164.6 up to 1256.6 ms.
// [R6] Codes 11000 to 11111 give 1728.1 up to 13196.4 ms.
// [R7] Trim bit 6 is read-only and reads 1 once trimming has completed.
// [R8] Trim bit 1 resets to 1 (disabled); writing 0 applies factory trim.
// [R9] Host starts the oscillator trim after every reset.
// [R10] Host enables factory trim by writing 0x00 to the trim register.
// [R11] Back-end fault low drives every PWM output and both valids low.
// [R12] After a fault the block waits the back-end period, then issues a reset.
// [R13] Back-end codes 0010 to 1010 give 299 up to 1496 ms; 0010 default.
// [R14] Code 1011 and codes with bits 3 and 2 set give 1496 ms.
// [R15] Host never programs back-end codes 0000 or 0001.
// [R16] Fault input is synchronised; all intervals count clock cycles.
`ifndef PWM_CTRL_PARAMS_SVH
`define PWM_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_START_STOP   8'h1A
`define IDX_OSC_TRIM     8'h1B
`define IDX_BACKEND      8'h1C
`define IDX_IRQ_STATUS   8'h1D
`define IDX_IRQ_MASK     8'h1E

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SS_LOAD_BIT      7
`define TRIM_DONE_BIT    6
`define TRIM_DIS_BIT     1
`define RST_START_STOP   8'h00
`define RST_OSC_TRIM     8'h82
`define RST_BACKEND      8'h02
`define TRIM_RSVD_ONES   8'h80
`define IRQ_BITS         5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    100
`define TICK_NS          100000
`define TICK_CYCLES      (`TICK_NS / `CLK_PERIOD_NS)
`define TRIM_TICKS       18'h0_0001
`define HALF_PWM_CYCLES  13

`endif

// ### inc/pwm_ctrl_pkg.sv
// Types shared by the PWM control block
`default_nettype none
package pwm_ctrl_pkg;
	typedef enum logic [2:0] {
		CH_OFF,
		CH_SOFT_START,
		CH_RUN,
		CH_SOFT_STOP,
		CH_FAULT_WAIT
	} ch_state_t;
	typedef logic [17:0] ticks_t;
endpackage : pwm_ctrl_pkg
`default_nettype wire

// ### testbench/power_stage_model.sv
// Power stage model: leaves the PWM outputs unused, raises a fault on command
`default_nettype none
module power_stage_model #(
	parameter int CHANNELS = 6
) (
	// Clock
	input  wire logic                clock,
	// From the control block
	input  wire logic [CHANNELS-1:0] pwm_out,
	input  wire logic                output_valid_a,
	input  wire logic                output_valid_b,
	// Fault command from the bench
	input  wire logic                fault_req,
	// Fault line back to the control block
	output logic                     backend_fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Stage reports a fault one edge after the command, like a real detector
	always @(posedge clock) begin
		backend_fault_n <= !fault_req;
	end
endmodule : power_stage_model
`default_nettype wire

// ### testbench/pwm_ctrl_properties.sv
// Concurrent checks on the ports of the PWM control block
`include "pwm_ctrl_params.svh"
`default_nettype none
module pwm_ctrl_properties #(
	parameter int CHANNELS = 6
) (
	// Clock and reset
	input wire logic                clock,
	input wire logic                srst,
	// APB
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [9:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// Power stage and control outputs
	input wire logic                backend_fault_n,
	input wire logic [CHANNELS-1:0] pwm_out,
	input wire logic                output_valid_a,
	input wire logic                output_valid_b,
	input wire logic                bridge_tied_load,
	input wire logic                single_ended_load,
	input wire logic                modulator_reset,
	input wire logic                factory_trim_select
);
	logic bad;
	assign bad = (paddr[1:0] != 2'b00) || !(paddr[9:2] inside
		{`IDX_START_STOP, `IDX_OSC_TRIM, `IDX_BACKEND, `IDX_IRQ_STATUS,
		`IDX_IRQ_MASK});
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	fault_low_a: assert property (!backend_fault_n [*3] |=>
		pwm_out == '0 && !output_valid_a && !output_valid_b)
		else $error("outputs not low during fault");
	valid_pair_a: assert property (output_valid_a == output_valid_b)
		else $error("valid outputs differ");
	load_pair_a: assert property (bridge_tied_load != single_ended_load)
		else $error("load selects not exclusive");
	ready_high_a: assert property (pready)
		else $error("pready low");
	decode_err_a: assert property (psel && penable |-> pslverr == bad)
		else $error("slave error does not match decode");
	reset_pulse_a: assert property (modulator_reset |->
		!output_valid_a ##1 !modulator_reset)
		else $error("modulator reset not a lone pulse in fault wait");
	trim_write_a: assert property ($rose(factory_trim_select) |->
		$past(psel && penable && pwrite && !pwdata[1] &&
		paddr == {`IDX_OSC_TRIM, 2'b00}))
		else $error("trim select without a write of zero");
	rdata_hold_a: assert property (!psel ##1 !psel |-> $stable(prdata))
		else $error("read data moved while idle");
endmodule : pwm_ctrl_properties
bind pwm_softstart_ctrl pwm_ctrl_properties #(.CHANNELS(CHANNELS))
	pwm_ctrl_properties_i (.clock(clock), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.backend_fault_n(backend_fault_n), .pwm_out(pwm_out),
	.output_valid_a(output_valid_a), .output_valid_b(output_valid_b),
	.bridge_tied_load(bridge_tied_load),
	.single_ended_load(single_ended_load),
	.modulator_reset(modulator_reset),
	.factory_trim_select(factory_trim_select));
`default_nettype wire

// ### testbench/test_pwm_softstart_ctrl.sv
// Self-checking bench of the PWM soft start, trim and fault control
`include "pwm_ctrl_params.svh"
`default_nettype none
module test_pwm_softstart_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int        CH = 6;
	localparam int        TC = 2;
	localparam int        HP = `HALF_PWM_CYCLES;
	localparam int        LIMIT = 90000;
	localparam bit [9:0]  A_SS = {`IDX_START_STOP, 2'b00};
	localparam bit [9:0]  A_OT = {`IDX_OSC_TRIM, 2'b00};
	localparam bit [9:0]  A_BE = {`IDX_BACKEND, 2'b00};
	localparam bit [9:0]  A_ST = {`IDX_IRQ_STATUS, 2'b00};
	localparam bit [9:0]  A_MK = {`IDX_IRQ_MASK, 2'b00};
	logic clock, srst, psel, penable, pwrite, pready, pslverr, irq;
	logic channels_on, fault_req, backend_fault_n, err;
	logic output_valid_a, output_valid_b, modulator_reset;
	logic bridge_tied_load, single_ended_load, factory_trim_select;
	logic [9:0]    paddr;
	logic [31:0]   pwdata, prdata, rd;
	logic [CH-1:0] pwm_in, pwm_out;
	int            n_fail, comparisons, cycles;
	pwm_softstart_ctrl #(.CHANNELS(CH), .TICK_CYCLES(TC), .HALF_PWM(HP))
		pwm_softstart_ctrl_i (.clock(clock), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channels_on(channels_on), .pwm_in(pwm_in),
		.backend_fault_n(backend_fault_n), .pwm_out(pwm_out),
		.output_valid_a(output_valid_a), .output_valid_b(output_valid_b),
		.bridge_tied_load(bridge_tied_load),
		.single_ended_load(single_ended_load),
		.modulator_reset(modulator_reset),
		.factory_trim_select(factory_trim_select), .irq(irq));
	power_stage_model #(.CHANNELS(CH)) power_stage_model_i (.clock(clock),
		.pwm_out(pwm_out), .output_valid_a(output_valid_a),
		.output_valid_b(output_valid_b), .fault_req(fault_req),
		.backend_fault_n(backend_fault_n));
	// ----------------------------------------------------------------
	// Clock, timeout and report
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #50 clock = !clock;
	end
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic win(input int n, input int lo);
		comparisons++;
		if (n < lo || n > lo + 10) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, n, lo);
		end
	endtask : win
	// Read data and error are taken at the pready edge; settle to negedge
	task automatic apb(input logic wr, input logic [9:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge clock);
	endtask : apb
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic regs_check;
		apb(1'b0, A_SS, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, A_OT, 32'h0);
		chk(rd, 32'h0000_0082);
		apb(1'b0, A_BE, 32'h0);
		chk(rd, 32'h0000_0002);
		apb(1'b0, A_MK, 32'h0);
		chk(rd, 32'h0000_0000);
		chk({bridge_tied_load, single_ended_load}, 32'h0000_0002);
		apb(1'b0, {8'h1F, 2'b00}, 32'h0);
		chk(err, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, A_SS + 10'h001, 32'h0000_00FF);
		chk(err, 32'h0000_0001);
		apb(1'b1, A_SS, 32'h0000_0080);
		chk({bridge_tied_load, single_ended_load}, 32'h0000_0001);
		apb(1'b0, A_SS, 32'h0);
		chk(rd, 32'h0000_0080);
		apb(1'b1, A_SS, 32'h0);
	endtask : regs_check
	task automatic trim_check;
		int n;
		apb(1'b1, A_OT, 32'h0000_0000);
		chk(factory_trim_select, 32'h0000_0001);
		n = 0;
		do begin
			apb(1'b0, A_OT, 32'h0);
			n++;
		end while (rd[6] !== 1'b1 && n < 20);
		chk(rd, 32'h0000_00C0);
		chk(irq, 32'h0000_0000);
		apb(1'b1, A_MK, 32'h0000_0010);
		chk(irq, 32'h0000_0001);
		apb(1'b1, A_ST, 32'h0000_0010);
		chk(irq, 32'h0000_0000);
		// Bit 6 is status only, so writing it must not set it
		apb(1'b1, A_OT, 32'h0000_0042);
		apb(1'b0, A_OT, 32'h0);
		chk(factory_trim_select, 32'h0000_0000);
		chk(rd, 32'h0000_0082);
		apb(1'b1, A_OT, 32'h0000_0000);
	endtask : trim_check
	task automatic soft_start(input logic [7:0] code, input int ticks);
		int n, bad, tog;
		logic [CH-1:0] prv;
		apb(1'b1, A_SS, {24'h0, code});
		prv = pwm_out;
		@(posedge clock);
		channels_on <= 1'b1;
		n = 0; bad = 0; tog = 0;
		do begin
			@(posedge clock);
			n++;
			if (n > 2 && pwm_out !== pwm_in) begin
				if (pwm_out !== '0 && pwm_out !== '1) bad++;
				if (pwm_out !== prv) tog++;
			end
			prv = pwm_out;
		end while (pwm_out !== pwm_in && n < ticks * TC + 50);
		win(n, ticks * TC - 2);
		chk(bad, 0);
		chk(tog >= n / HP - 3 && tog <= n / HP + 1, 1);
		chk(output_valid_a, 32'h0000_0001);
	endtask : soft_start
	task automatic soft_stop(input int ticks);
		int n, bad;
		@(posedge clock);
		channels_on <= 1'b0;
		n = 0; bad = 0;
		do begin
			@(posedge clock);
			n++;
			if (n > 2 && output_valid_a === 1'b1 && pwm_out !== '0 &&
				pwm_out !== '1) bad++;
		end while (output_valid_a !== 1'b0 && n < ticks * TC + 50);
		win(n, ticks * TC - 2);
		chk(bad, 0);
	endtask : soft_stop
	task automatic fault(input logic [3:0] code, input int ticks);
		int n;
		apb(1'b1, A_BE, {28'h0, code});
		@(posedge clock);
		fault_req <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
			if (n == 6) begin
				chk({pwm_out, output_valid_a, output_valid_b}, 0);
				fault_req <= 1'b0;
			end
		end while (modulator_reset !== 1'b1 && n < ticks * TC + 50);
		win(n, ticks * TC);
		apb(1'b0, A_ST, 32'h0);
		chk(rd[3:2], 32'h0000_0003);
		apb(1'b1, A_ST, 32'h0000_001F);
		repeat (8) @(posedge clock);
		chk(pwm_out, pwm_in);
	endtask : fault
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; channels_on = 1'b0; fault_req = 1'b0;
		pwm_in = 6'h2D; n_fail = 0; comparisons = 0; cycles = 0;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		regs_check;
		trim_check;
		soft_start(8'h08, 165);
		soft_stop(165);
		soft_start(8'h10, 1646);
		apb(1'b1, A_SS, 32'h0);
		soft_stop(0);
		soft_start(8'h18, 17281);
		apb(1'b1, A_SS, 32'h0);
		fault(4'h2, 2990);
		fault(4'hC, 14960);
		soft_stop(0);
		test_done;
	end
endmodule : test_pwm_softstart_ctrl
`default_nettype wire
